/* ultrasonic_regs_pkg.sv */
// constants, types and helpers for the ultrasonic control and status register bank
`default_nettype none

package ultrasonic_regs_pkg;

    // register addresses on the serial port
    localparam logic [5:0] ADDR_ECHO   = 6'h17;
    localparam logic [5:0] ADDR_ZC     = 6'h18;
    localparam logic [5:0] ADDR_BURST  = 6'h1A;
    localparam logic [5:0] ADDR_MODE   = 6'h1B;
    localparam logic [5:0] ADDR_STATUS = 6'h1C;

    // reset values
    localparam logic [7:0] ECHO_RESET   = 8'h07;
    localparam logic [7:0] ZC_RESET     = 8'h14;
    localparam logic [7:0] BURST_RESET  = 8'h00;
    localparam logic [7:0] MODE_RESET   = 8'h00;

    // writable bits; the rest are reserved and read as zero
    localparam logic [7:0] ECHO_WMASK  = 8'h1F;
    localparam logic [7:0] ZC_WMASK    = 8'hFF;
    localparam logic [7:0] BURST_WMASK = 8'hFF;
    localparam logic [7:0] MODE_WMASK  = 8'hC3;

    // field positions
    localparam int ECHO_EN_BIT     = 4;
    localparam int ECHO_THR_MSB    = 3;
    localparam int ZC_EN_BIT       = 7;
    localparam int ZC_GATE_BIT     = 6;
    localparam int ZC_INSEL_BIT    = 5;
    localparam int ZC_STG_MSB      = 4;
    localparam int ZC_STG_LSB      = 3;
    localparam int ZC_HYST_MSB     = 2;
    localparam int HALF_BRG_BIT    = 7;
    localparam int PRE_DRV_BIT     = 6;
    localparam int PULSE_MSB       = 5;
    localparam int SLEEP_BIT       = 7;
    localparam int STDBY_BIT       = 6;
    localparam int CHARGE_TRIG_BIT = 1;
    localparam int BURST_CMD_BIT   = 0;
    localparam int READY_BIT       = 3;
    localparam int PCNT_FLT_BIT    = 2;
    localparam int STUCK_FLT_BIT   = 1;
    localparam int CRC_FLT_BIT     = 0;

    // echo threshold in millivolts: base plus step times code
    localparam logic [10:0] THR_LO_BASE_MV = 11'h190;
    localparam logic [10:0] THR_LO_STEP_MV = 11'h028;
    localparam logic [10:0] THR_HI_BASE_MV = 11'h258;
    localparam logic [10:0] THR_HI_STEP_MV = 11'h03C;

    // io mode in which the burst command bit is honoured
    localparam logic [1:0] IO_MODE_CMD     = 2'h0;
    localparam logic [2:0] STUCK_CHECK_OFF = 3'h7;

    // stuck driver timeouts
    localparam int SYS_CLK_MHZ  = 20;
    localparam int STUCK_T0_US  = 64;
    localparam int STUCK_T1_US  = 48;
    localparam int STUCK_T2_US  = 32;
    localparam int STUCK_T3_US  = 24;
    localparam int STUCK_T4_US  = 16;
    localparam int STUCK_T5_US  = 8;
    localparam int STUCK_T6_US  = 4;
    localparam logic [10:0] STUCK_C0 = 11'(STUCK_T0_US * SYS_CLK_MHZ);
    localparam logic [10:0] STUCK_C1 = 11'(STUCK_T1_US * SYS_CLK_MHZ);
    localparam logic [10:0] STUCK_C2 = 11'(STUCK_T2_US * SYS_CLK_MHZ);
    localparam logic [10:0] STUCK_C3 = 11'(STUCK_T3_US * SYS_CLK_MHZ);
    localparam logic [10:0] STUCK_C4 = 11'(STUCK_T4_US * SYS_CLK_MHZ);
    localparam logic [10:0] STUCK_C5 = 11'(STUCK_T5_US * SYS_CLK_MHZ);
    localparam logic [10:0] STUCK_C6 = 11'(STUCK_T6_US * SYS_CLK_MHZ);
    localparam logic [10:0] IDLE_MAX = 11'h7FF;

    // serial frame: read flag, six address bits, spare, eight data bits
    localparam logic [4:0] HEADER_LAST = 5'h07;
    localparam logic [4:0] FRAME_LAST  = 5'h0F;

    typedef enum logic [1:0] {
        PH_HEAD = 2'b00,
        PH_DATA = 2'b01,
        PH_DONE = 2'b10
    } spi_phase_t;

    typedef struct packed {
        logic       sleep;
        logic       standby;
        logic       half_bridge;
        logic       pre_driver;
        logic       zc_input_sel;
        logic [1:0] zc_stage;
        logic [2:0] zc_hyst;
        logic       charge_enable;
        logic       burst_enable;
    } front_end_cfg_t;

    function automatic logic [10:0] thr_mv(input logic [3:0] code, input logic scale);
        if (scale) begin
            thr_mv = THR_HI_BASE_MV + THR_HI_STEP_MV * {7'h00, code};
        end else begin
            thr_mv = THR_LO_BASE_MV + THR_LO_STEP_MV * {7'h00, code};
        end
    endfunction

    function automatic logic [10:0] stuck_limit(input logic [2:0] code);
        case (code)
            3'h0:    stuck_limit = STUCK_C0;
            3'h1:    stuck_limit = STUCK_C1;
            3'h2:    stuck_limit = STUCK_C2;
            3'h3:    stuck_limit = STUCK_C3;
            3'h4:    stuck_limit = STUCK_C4;
            3'h5:    stuck_limit = STUCK_C5;
            3'h6:    stuck_limit = STUCK_C6;
            default: stuck_limit = IDLE_MAX;
        endcase
    endfunction

endpackage

`default_nettype wire

/* burst_fault_monitor.sv */
// pulse count and stuck driver checks during a burst
`timescale 1ns/1ns
`default_nettype none

module burst_fault_monitor
    import ultrasonic_regs_pkg::*;
(
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    // burst state and pulse pin
    input  wire logic       burst_on,
    input  wire logic       pulse_pin,
    input  wire logic [5:0] pulse_target,
    input  wire logic [2:0] deglitch,
    input  wire logic       clear_faults,
    // sticky flags
    output logic            pulse_fault_q,
    output logic            stuck_fault_q
);

    logic        pin_q;
    logic        burst_q;
    logic [6:0]  count_q;
    logic [10:0] idle_q;
    logic        toggle;
    logic        end_short;
    logic        stuck_hit;

    assign toggle    = pulse_pin ^ pin_q;
    assign end_short = burst_q && !burst_on && (pulse_target != 6'h00)
                       && (count_q < {1'b0, pulse_target});
    assign stuck_hit = burst_on && (deglitch != STUCK_CHECK_OFF)
                       && (idle_q >= stuck_limit(deglitch));

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            pin_q   <= 1'b0;
            burst_q <= 1'b0;
        end else begin
            pin_q   <= pulse_pin;
            burst_q <= burst_on;
        end
    end

    // saturates so a long continuous burst cannot wrap
    always_ff @(posedge clk_sys) begin
        if (!rst_n || !burst_on) begin
            count_q <= 7'h00;
        end else if (pulse_pin && !pin_q && count_q != 7'h7F) begin
            count_q <= count_q + 7'h01;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n || !burst_on || toggle) begin
            idle_q <= 11'h000;
        end else if (idle_q != IDLE_MAX) begin
            idle_q <= idle_q + 11'h001;
        end
    end

    // a new fault wins over a read clear in the same cycle
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            pulse_fault_q <= 1'b0;
        end else if (end_short) begin
            pulse_fault_q <= 1'b1;
        end else if (clear_faults) begin
            pulse_fault_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            stuck_fault_q <= 1'b0;
        end else if (stuck_hit) begin
            stuck_fault_q <= 1'b1;
        end else if (clear_faults) begin
            stuck_fault_q <= 1'b0;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    chk_short_burst_flag: assert property (end_short |=> pulse_fault_q)
        else $error("short burst did not raise pulse count fault");
    chk_stuck_flag_set: assert property (stuck_hit |=> stuck_fault_q)
        else $error("stuck driver timeout did not raise fault");
    chk_stuck_check_off: assert property (
        (deglitch == STUCK_CHECK_OFF && !stuck_fault_q) |=> !stuck_fault_q)
        else $error("stuck fault raised with check disabled");
    cov_burst_end: cover property (burst_q && !burst_on && pulse_target != 6'h00);

endmodule

`default_nettype wire

/* ultrasonic_ctrl_status_regs.sv */
// control and status register bank of the ultrasonic driver and receiver front end
`timescale 1ns/1ns
`default_nettype none

module ultrasonic_ctrl_status_regs
    import ultrasonic_regs_pkg::*;
(
    // clock and reset
    input  wire logic        CLK_SYS,
    input  wire logic        RST_N,
    // serial register port
    input  wire logic        SPI_CS_N,
    input  wire logic        SPI_SCLK,
    input  wire logic        SPI_MOSI,
    output logic             SPI_MISO,
    output logic             SPI_MISO_OE,
    // fields held in neighbouring registers
    input  wire logic [1:0]  IO_MODE,
    input  wire logic [2:0]  STUCK_DRIVER_DEGLITCH_TIME,
    input  wire logic        LISTEN_CHARGE_AUTO_OFF,
    input  wire logic        DRIVE_SUPPLY_HIGH_IMPEDANCE,
    input  wire logic        OUTPUT_SCALE_SELECT,
    // front end sense
    input  wire logic [10:0] ECHO_LEVEL_MV,
    input  wire logic [3:0]  ZC_POS_MINUS_CM,
    input  wire logic [3:0]  ZC_POS_MINUS_NEG,
    input  wire logic        BURST_CONTROL_PIN_TWO,
    input  wire logic        DRIVE_SUPPLY_AT_LEVEL,
    input  wire logic        NVM_CHECKSUM_BAD,
    // outputs to pins and analog
    output logic             THRESHOLD_CROSSING_OUTPUT,
    output logic             ZERO_CROSS_OUTPUT,
    output front_end_cfg_t   FRONT_END_CFG
);

    logic [7:0]  echo_q;
    logic [7:0]  zc_q;
    logic [7:0]  burst_q;
    logic [7:0]  mode_q;
    logic        ready_q;
    logic        crc_q;
    logic        pcnt_flt;
    logic        stuck_flt;
    logic [7:0]  status_word;

    logic        sclk_q;
    logic [4:0]  bit_cnt_q;
    logic [6:0]  shift_q;
    logic        rd_q;
    logic [5:0]  addr_q;
    logic [7:0]  out_q;
    logic        miso_q;
    spi_phase_t  phase_q;

    logic        sclk_rise;
    logic        sclk_fall;
    logic        header_done;
    logic        frame_done;
    logic        wr_en;
    logic [7:0]  wdata;
    logic        status_read;
    logic        burst_en;
    logic        echo_hit;
    logic        zc_src;
    logic        charge_d;

    function automatic logic [7:0] read_word(input logic [5:0] addr,
                                             input logic [7:0] echo,
                                             input logic [7:0] zc,
                                             input logic [7:0] burst,
                                             input logic [7:0] mode,
                                             input logic [7:0] status);
        case (addr)
            ADDR_ECHO:   read_word = echo;
            ADDR_ZC:     read_word = zc;
            ADDR_BURST:  read_word = burst;
            ADDR_MODE:   read_word = mode;
            ADDR_STATUS: read_word = status;
            default:     read_word = 8'h00;
        endcase
    endfunction

    // serial framing; sclk is sampled as an ordinary synchronous input
    assign sclk_rise   = SPI_SCLK && !sclk_q;
    assign sclk_fall   = !SPI_SCLK && sclk_q;
    assign header_done = !SPI_CS_N && sclk_rise && phase_q == PH_HEAD
                         && bit_cnt_q == HEADER_LAST;
    assign frame_done  = !SPI_CS_N && sclk_rise && phase_q == PH_DATA
                         && bit_cnt_q == FRAME_LAST;
    assign wdata       = {shift_q, SPI_MOSI};
    assign wr_en       = frame_done && !rd_q;
    assign status_read = header_done && shift_q[6] && shift_q[5:0] == ADDR_STATUS;
    assign SPI_MISO    = miso_q;
    assign SPI_MISO_OE = !SPI_CS_N;

    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            sclk_q <= 1'b0;
        end else begin
            sclk_q <= SPI_SCLK;
        end
    end

    // a frame cut short by chip select writes no configuration register
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N || SPI_CS_N) begin
            phase_q <= PH_HEAD;
        end else begin
            case (phase_q)
                PH_HEAD: begin
                    if (header_done) begin
                        phase_q <= PH_DATA;
                    end
                end
                PH_DATA: begin
                    if (frame_done) begin
                        phase_q <= PH_DONE;
                    end
                end
                PH_DONE: phase_q <= PH_DONE;
                default: phase_q <= PH_HEAD;
            endcase
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RST_N || SPI_CS_N) begin
            bit_cnt_q <= 5'h00;
            shift_q   <= 7'h00;
        end else if (sclk_rise && phase_q != PH_DONE) begin
            bit_cnt_q <= bit_cnt_q + 5'h01;
            shift_q   <= {shift_q[5:0], SPI_MOSI};
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            rd_q   <= 1'b0;
            addr_q <= 6'h00;
        end else if (header_done) begin
            rd_q   <= shift_q[6];
            addr_q <= shift_q[5:0];
        end
    end

    // read data is captured at the header so later updates cannot tear a byte
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N || SPI_CS_N) begin
            out_q  <= 8'h00;
            miso_q <= 1'b0;
        end else if (header_done) begin
            out_q <= shift_q[6] ? read_word(shift_q[5:0], echo_q, zc_q, burst_q,
                                            mode_q, status_word) : 8'h00;
        end else if (sclk_fall && phase_q == PH_DATA) begin
            miso_q <= out_q[7];
            out_q  <= {out_q[6:0], 1'b0};
        end
    end

    // configuration registers; masks keep reserved bits at zero
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            echo_q  <= ECHO_RESET;
            zc_q    <= ZC_RESET;
            burst_q <= BURST_RESET;
            mode_q  <= MODE_RESET;
        end else if (wr_en) begin
            case (addr_q)
                ADDR_ECHO:  echo_q  <= wdata & ECHO_WMASK;
                ADDR_ZC:    zc_q    <= wdata & ZC_WMASK;
                ADDR_BURST: burst_q <= wdata & BURST_WMASK;
                ADDR_MODE:  mode_q  <= wdata & MODE_WMASK;
                default:    echo_q  <= echo_q;
            endcase
        end
    end

    // status bits track their sources; pulse count and stuck faults are sticky until read
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            ready_q <= 1'b0;
            crc_q   <= 1'b0;
        end else begin
            ready_q <= DRIVE_SUPPLY_AT_LEVEL;
            crc_q   <= NVM_CHECKSUM_BAD;
        end
    end

    always_comb begin
        status_word                = 8'h00;
        status_word[READY_BIT]     = ready_q;
        status_word[PCNT_FLT_BIT]  = pcnt_flt;
        status_word[STUCK_FLT_BIT] = stuck_flt;
        status_word[CRC_FLT_BIT]   = crc_q;
    end

    // only io mode zero lets software start a burst
    assign burst_en = mode_q[BURST_CMD_BIT] && IO_MODE == IO_MODE_CMD;

    burst_fault_monitor u_monitor (
        .clk_sys       (CLK_SYS),
        .rst_n         (RST_N),
        .burst_on      (burst_en),
        .pulse_pin     (BURST_CONTROL_PIN_TWO),
        .pulse_target  (burst_q[PULSE_MSB:0]),
        .deglitch      (STUCK_DRIVER_DEGLITCH_TIME),
        .clear_faults  (status_read),
        .pulse_fault_q (pcnt_flt),
        .stuck_fault_q (stuck_flt)
    );

    // comparators
    assign echo_hit = echo_q[ECHO_EN_BIT] && ECHO_LEVEL_MV >=
                      thr_mv(echo_q[ECHO_THR_MSB:0], OUTPUT_SCALE_SELECT);
    assign zc_src   = zc_q[ZC_INSEL_BIT] ? ZC_POS_MINUS_NEG[zc_q[ZC_STG_MSB:ZC_STG_LSB]]
                                         : ZC_POS_MINUS_CM[zc_q[ZC_STG_MSB:ZC_STG_LSB]];

    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            THRESHOLD_CROSSING_OUTPUT <= 1'b0;
            ZERO_CROSS_OUTPUT         <= 1'b0;
        end else begin
            THRESHOLD_CROSSING_OUTPUT <= echo_hit;
            ZERO_CROSS_OUTPUT         <= zc_q[ZC_EN_BIT] && zc_src
                                         && (!zc_q[ZC_GATE_BIT] || echo_hit);
        end
    end

    // charging off in high impedance; with auto-off it follows trigger or burst
    assign charge_d = !DRIVE_SUPPLY_HIGH_IMPEDANCE
                      && (!LISTEN_CHARGE_AUTO_OFF || mode_q[CHARGE_TRIG_BIT] || burst_en);

    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            FRONT_END_CFG <= '0;
        end else begin
            FRONT_END_CFG.sleep         <= mode_q[SLEEP_BIT];
            FRONT_END_CFG.standby       <= mode_q[STDBY_BIT];
            FRONT_END_CFG.half_bridge   <= burst_q[HALF_BRG_BIT];
            FRONT_END_CFG.pre_driver    <= burst_q[PRE_DRV_BIT];
            FRONT_END_CFG.zc_input_sel  <= zc_q[ZC_INSEL_BIT];
            FRONT_END_CFG.zc_stage      <= zc_q[ZC_STG_MSB:ZC_STG_LSB];
            FRONT_END_CFG.zc_hyst       <= zc_q[ZC_HYST_MSB:0];
            FRONT_END_CFG.charge_enable <= charge_d;
            FRONT_END_CFG.burst_enable  <= burst_en;
        end
    end

    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);

    chk_echo_out_off: assert property (
        !echo_q[ECHO_EN_BIT] |=> !THRESHOLD_CROSSING_OUTPUT)
        else $error("threshold output active while comparator disabled");
    chk_echo_low_scale: assert property (
        (echo_q[ECHO_EN_BIT] && !OUTPUT_SCALE_SELECT && ECHO_LEVEL_MV >=
         11'h190 + 11'h028 * {7'h00, echo_q[3:0]}) |=> THRESHOLD_CROSSING_OUTPUT)
        else $error("low scale threshold crossing missed");
    chk_echo_high_scale: assert property (
        (echo_q[ECHO_EN_BIT] && OUTPUT_SCALE_SELECT && ECHO_LEVEL_MV <
         11'h258 + 11'h03C * {7'h00, echo_q[3:0]}) |=> !THRESHOLD_CROSSING_OUTPUT)
        else $error("high scale threshold crossing too early");
    chk_zc_out_off: assert property (
        !zc_q[ZC_EN_BIT] |=> !ZERO_CROSS_OUTPUT)
        else $error("zero-cross output active while disabled");
    chk_zc_echo_gate: assert property (
        (zc_q[ZC_GATE_BIT] && !echo_hit) |=> !ZERO_CROSS_OUTPUT)
        else $error("zero-cross passed without echo detection");
    chk_zc_input_path: assert property (
        (zc_q[ZC_EN_BIT] && !zc_q[ZC_GATE_BIT] && zc_q[ZC_INSEL_BIT]
         && ZC_POS_MINUS_NEG[zc_q[4:3]]) |=> ZERO_CROSS_OUTPUT)
        else $error("selected zero-cross input not passed");
    chk_reset_values: assert property (
        $past(!RST_N) |-> (zc_q == 8'h14 && echo_q == 8'h07 && mode_q == 8'h00))
        else $error("register reset value wrong");
    chk_zc_write_lands: assert property (
        (wr_en && addr_q == 6'h18) |=> zc_q == $past(wdata))
        else $error("write to zero-cross register lost");
    chk_reserved_zero: assert property (
        wr_en |=> (echo_q[7:5] == 3'h0 && mode_q[5:2] == 4'h0))
        else $error("reserved bits took a write");
    chk_burst_io_gate: assert property (
        (IO_MODE != 2'h0) |=> !FRONT_END_CFG.burst_enable)
        else $error("burst enabled outside io mode zero");
    chk_hiz_charge: assert property (
        DRIVE_SUPPLY_HIGH_IMPEDANCE |=> !FRONT_END_CFG.charge_enable)
        else $error("charging on in high impedance");
    chk_auto_off: assert property (
        (LISTEN_CHARGE_AUTO_OFF && !mode_q[1] && !burst_en) |=> !FRONT_END_CFG.charge_enable)
        else $error("charging not stopped after burst");
    chk_ready_track: assert property (
        DRIVE_SUPPLY_AT_LEVEL |=> status_word[READY_BIT])
        else $error("ready flag does not follow supply");

    cov_burst_run: cover property (burst_en ##1 FRONT_END_CFG.burst_enable);
    cov_status_read: cover property (status_read && (pcnt_flt || stuck_flt));
    cov_write_frame: cover property (wr_en && addr_q == ADDR_MODE);

endmodule

`default_nettype wire

/* mcu_model.sv */
// microcontroller model that drives the serial register port
`timescale 1ns/1ns
`default_nettype none

module mcu_model (
    // serial port seen from the controller
    input  wire logic CLK_SYS,
    input  wire logic SPI_MISO,
    output logic      SPI_CS_N = 1'b1,
    output logic      SPI_SCLK = 1'b0,
    output logic      SPI_MOSI = 1'b0
);
    // each clock phase lasts two system cycles; the port needs only one to see an edge
    task automatic xfer(input logic [15:0] f, output logic [7:0] rd);
        @(negedge CLK_SYS) SPI_CS_N = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            @(negedge CLK_SYS) SPI_MOSI = f[i];
            @(negedge CLK_SYS) SPI_SCLK = 1'b1;
            if (i < 8) rd[i] = SPI_MISO;
            repeat (2) @(negedge CLK_SYS);
            SPI_SCLK = 1'b0;
        end
        repeat (2) @(negedge CLK_SYS);
        SPI_CS_N = 1'b1;
        // released data line flips so a stale bit is never trusted
        SPI_MOSI = ~SPI_MOSI;
    endtask
endmodule

`default_nettype wire

/* ultrasonic_ctrl_status_regs_test.sv */
// self-checking bench for the ultrasonic control and status register bank
`timescale 1ns/1ns
`default_nettype none

module ultrasonic_ctrl_status_regs_test
    import ultrasonic_regs_pkg::*;
;
    logic           clk_sys = 1'b0;
    logic           rst_n = 1'b0;
    logic           cs_n, sclk, mosi, miso, miso_oe, thr_o, zc_o;
    logic [1:0]     io_mode = 2'h1;
    logic [2:0]     dgl = 3'h7;
    logic           auto_off = 1'b1, hiz = 1'b0, scale = 1'b0, at_lvl = 1'b0, nvm = 1'b0;
    logic [10:0]    lvl = 11'h000;
    logic [3:0]     zc_cm = 4'h0, zc_nn = 4'h0;
    logic           pin2 = 1'b0;
    front_end_cfg_t fe;
    int             error_cnt = 0, samples_checked = 0, cyc = 0;

    ultrasonic_ctrl_status_regs dut (
        .CLK_SYS(clk_sys), .RST_N(rst_n), .SPI_CS_N(cs_n), .SPI_SCLK(sclk),
        .SPI_MOSI(mosi), .SPI_MISO(miso), .SPI_MISO_OE(miso_oe), .IO_MODE(io_mode),
        .STUCK_DRIVER_DEGLITCH_TIME(dgl), .LISTEN_CHARGE_AUTO_OFF(auto_off),
        .DRIVE_SUPPLY_HIGH_IMPEDANCE(hiz), .OUTPUT_SCALE_SELECT(scale), .ECHO_LEVEL_MV(lvl),
        .ZC_POS_MINUS_CM(zc_cm), .ZC_POS_MINUS_NEG(zc_nn), .BURST_CONTROL_PIN_TWO(pin2),
        .DRIVE_SUPPLY_AT_LEVEL(at_lvl), .NVM_CHECKSUM_BAD(nvm),
        .THRESHOLD_CROSSING_OUTPUT(thr_o), .ZERO_CROSS_OUTPUT(zc_o), .FRONT_END_CFG(fe)
    );
    mcu_model mcu (
        .CLK_SYS(clk_sys), .SPI_MISO(miso), .SPI_CS_N(cs_n), .SPI_SCLK(sclk), .SPI_MOSI(mosi)
    );

    task automatic tally_and_finish;
        if (error_cnt == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic cmp(input logic [11:0] g, input logic [11:0] e);
        samples_checked++;
        if (g !== e) $display("[ERR] %0t got %h want %h", $time, g, e);
        if (g !== e) error_cnt++;
    endtask
    // on a read the data argument is the expected value
    task automatic rw(input logic r, input logic [5:0] a, input logic [7:0] d);
        logic [7:0] x;
        mcu.xfer({r, a, 1'b0, d}, x);
        if (r) cmp(12'(x), 12'(d));
    endtask
    task automatic t_regs;
        logic [5:0] a [5] = '{ADDR_ECHO, ADDR_ZC, ADDR_BURST, ADDR_MODE, ADDR_STATUS};
        logic [7:0] r [5] = '{8'h07, 8'h14, 8'h00, 8'h00, 8'h00};
        logic [7:0] m [5] = '{8'h1F, 8'hFF, 8'hFF, 8'hC3, 8'h00};
        for (int i = 0; i < 5; i++) begin
            rw(1'b1, a[i], r[i]);
            rw(1'b0, a[i], 8'hFF);
            rw(1'b1, a[i], m[i]);
        end
        rw(1'b1, 6'h10, 8'h00);
        at_lvl = 1'b1;
        nvm = 1'b1;
        rw(1'b1, ADDR_STATUS, 8'h09);
    endtask
    task automatic t_cfg;
        rw(1'b0, ADDR_BURST, 8'hC5);
        rw(1'b0, ADDR_ZC, 8'h2B);
        rw(1'b0, ADDR_MODE, 8'hC3);
        cmp(fe, 12'hFAE);
        io_mode = 2'h0;
        repeat (3) @(negedge clk_sys);
        cmp(fe, 12'hFAF);
        hiz = 1'b1;
        repeat (3) @(negedge clk_sys);
        cmp(fe, 12'hFAD);
        hiz = 1'b0;
        rw(1'b0, ADDR_MODE, 8'h00);
        cmp(fe, 12'h3AC);
        rw(1'b1, ADDR_STATUS, 8'h0D);
        rw(1'b1, ADDR_STATUS, 8'h09);
    endtask
    task automatic t_stuck;
        // a burst that gets all of its pulses must leave the count fault clear
        rw(1'b0, ADDR_BURST, 8'h02);
        rw(1'b0, ADDR_MODE, 8'h01);
        repeat (4) @(negedge clk_sys) pin2 = ~pin2;
        rw(1'b0, ADDR_MODE, 8'h00);
        rw(1'b1, ADDR_STATUS, 8'h09);
        rw(1'b0, ADDR_BURST, 8'h00);
        dgl = 3'h6;
        rw(1'b0, ADDR_MODE, 8'h01);
        repeat (100) @(negedge clk_sys);
        rw(1'b0, ADDR_MODE, 8'h00);
        rw(1'b1, ADDR_STATUS, 8'h0B);
    endtask
    task automatic t_thr;
        logic [10:0] l [4] = '{11'h2A8, 11'h2A7, 11'h3FC, 11'h3FB};
        rw(1'b0, ADDR_ECHO, 8'h17);
        for (int i = 0; i < 4; i++) begin
            scale = i[1];
            lvl = l[i];
            repeat (3) @(negedge clk_sys);
            cmp(12'(thr_o), i[0] ? 12'h000 : 12'h001);
        end
        lvl = 11'h7FF;
        rw(1'b0, ADDR_ECHO, 8'h07);
        cmp(12'(thr_o), 12'h000);
    endtask
    // stage one carries a crossing only on the negative input, zc_nn
    task automatic t_zc;
        logic [7:0] z [5] = '{8'hA8, 8'h88, 8'hE8, 8'hE8, 8'h68};
        logic [4:0] w = 5'b01001;
        zc_nn = 4'h2;
        zc_cm = 4'hD;
        for (int i = 0; i < 5; i++) begin
            if (i == 3) rw(1'b0, ADDR_ECHO, 8'h17);
            rw(1'b0, ADDR_ZC, z[i]);
            cmp(12'(zc_o), {11'h000, w[i]});
        end
    endtask

    initial forever #25 clk_sys = ~clk_sys;
    // the whole run needs about 3000 cycles
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (10) @(negedge clk_sys);
        rst_n = 1'b1;
        t_regs();
        t_cfg();
        t_stuck();
        t_thr();
        t_zc();
        tally_and_finish();
    end
endmodule

`default_nettype wire
